// [hw/card_clk_gen.sv]
// glitch-free card clock generator: crystal divider, oscillator half, stop
`timescale 1ns/10ps
`default_nettype none
module card_clk_gen
    import card_clock_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_xtal_level,
    input  wire logic       i_xtal_rise,
    input  wire logic       i_xtal_fall,
    input  wire logic       i_osc_rise,
    input  wire logic [2:0] i_select,
    input  wire logic       i_halt,
    input  wire logic       i_stop_high,
    output logic            o_clk,
    output logic            o_osc_active,
    output logic            o_switched,
    output logic            o_halted
);
    gen_state_t state;
    logic [2:0] active_sel;
    logic [1:0] cnt;
    logic       full;
    logic       src_rise;
    logic [1:0] half_m1;
    logic       tick;
    logic       next_clk;

    // half-period length per select code
    function automatic logic [1:0] half_len(input logic [2:0] sel);
        if (sel[SEL_TOP_BIT])
            return HALF_M1_DIV2;             // any code with top bit: half oscillator
        unique case (sel[1:0])
            SEL_QUARTER[1:0]: return HALF_M1_DIV4;
            SEL_EIGHTH[1:0]:  return HALF_M1_DIV8;
            default:          return HALF_M1_DIV2;
        endcase
    endfunction

    // next level of the running clock
    always_comb begin
        full     = (active_sel == SEL_FULL);                            // RULE13
        src_rise = active_sel[SEL_TOP_BIT] ? i_osc_rise : i_xtal_rise;  // RULE13
        half_m1  = half_len(active_sel);                                // RULE13
        tick     = src_rise && (cnt == half_m1);
        if (full)
            next_clk = i_xtal_level;         // RULE12
        else
            next_clk = tick ? ~o_clk : o_clk;  // RULE3
    end

    // source selection, divider and stop sequencing
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state      <= ST_RUN;
            active_sel <= SEL_FULL;
            cnt        <= 2'h0;
            o_clk      <= 1'b0;
            o_switched <= 1'b0;
        end else begin
            o_switched <= 1'b0;
            unique case (state)
                ST_RUN: begin
                    if (i_halt && (o_clk == i_stop_high)) begin
                        state <= ST_HALT;            // RULE2
                    end else if ((i_select != active_sel) && o_clk && !next_clk) begin
                        // adopt only at a falling edge so no high phase is cut
                        active_sel <= i_select;      // RULE4
                        cnt        <= 2'h0;
                        o_clk      <= 1'b0;
                        state      <= ST_ALIGN;
                        o_switched <= i_select[SEL_TOP_BIT] != active_sel[SEL_TOP_BIT]; // RULE10
                    end else begin
                        o_clk <= next_clk;           // RULE3
                        if (tick)
                            cnt <= 2'h0;
                        else if (src_rise)
                            cnt <= cnt + 2'h1;
                    end
                end
                ST_ALIGN: begin
                    // one new-source edge is spent so the low phase is never short
                    if (i_halt && !i_stop_high)
                        state <= ST_HALT;            // RULE1
                    else if (full ? i_xtal_fall : src_rise)
                        state <= ST_RUN;             // RULE4 RULE11
                end
                ST_HALT: begin
                    o_clk <= i_stop_high;            // RULE1
                    if (!i_halt) begin
                        if (o_clk) begin
                            state <= ST_RUN;         // resumes the high phase from the cnt held since the stop
                        end else begin
                            active_sel <= i_select;  // RULE4
                            cnt        <= 2'h0;
                            state      <= ST_ALIGN;
                            o_switched <= i_select[SEL_TOP_BIT] != active_sel[SEL_TOP_BIT];
                        end
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    assign o_osc_active = active_sel[SEL_TOP_BIT];
    assign o_halted     = (state == ST_HALT);
endmodule
`default_nettype wire

// [hw/card_clock_pkg.sv]
// shared constants, types and register map of the card clock selector
package card_clock_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] CFG_INDEX        = 8'h01; // card_clock_config
    localparam logic [7:0] STATUS_INDEX     = 8'h0C; // mixed_status_register
    localparam logic [7:0] DATA_INDEX       = 8'h0D; // receive (read) / transmit (write)
    localparam logic [7:0] MODE_INDEX       = 8'h10; // card mode control
    localparam logic [7:0] IRQ_STATUS_INDEX = 8'h11; // sticky event bits
    localparam logic [7:0] IRQ_MASK_INDEX   = 8'h12; // event enables

    // ****************************************************************
    // reset values and field positions
    // ****************************************************************
    localparam logic [7:0]  CFG_RESET         = 8'h00;
    localparam logic [7:0]  MODE_RESET        = 8'h00;
    localparam logic [7:0]  IRQ_MASK_RESET    = 8'h00;
    localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;
    localparam int          SEL_TOP_BIT       = 2;  // async_clock_select_top
    localparam int          SWITCHED_FLAG_BIT = 7;  // clock_switched_flag in status
    localparam int          RX_BIT            = 0;  // receive_bit_zero
    localparam int          IRQ_SWITCH_BIT    = 0;  // source change took effect
    localparam int          IRQ_HALT_BIT      = 1;  // clock reached stop level
    localparam int          IRQ_W             = 2;

    // ****************************************************************
    // clock select codes and half-period lengths in source edges
    // ****************************************************************
    localparam logic [2:0] SEL_FULL     = 3'h0;
    localparam logic [2:0] SEL_HALF     = 3'h1;
    localparam logic [2:0] SEL_QUARTER  = 3'h2;
    localparam logic [2:0] SEL_EIGHTH   = 3'h3;
    localparam logic [1:0] HALF_M1_DIV2 = 2'h0; // one source edge per phase
    localparam logic [1:0] HALF_M1_DIV4 = 2'h1; // two source edges per phase
    localparam logic [1:0] HALF_M1_DIV8 = 2'h3; // four source edges per phase

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic [1:0] unused;
        logic       stop_level_high;
        logic       clock_halt;
        logic       sync_card_clock_bit;
        logic [2:0] async_clock_select;
    } card_clock_config_t;

    typedef struct packed {
        logic [5:0] unused;
        logic       sync_tx_enable;
        logic       sync_card_mode;
    } card_mode_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_ALIGN = 2'b01,
        ST_HALT  = 2'b11
    } gen_state_t;

endpackage

// [hw/card_clock_selector.sv]
// card clock selector top: register slave, sync-card path, interrupt
//
// How it works
// RULE1 - stopped clock sits at chosen stop level
// RULE2 - halt bit one stops asynchronous card clock
// RULE3 - halt zero runs clock at selected frequency
// RULE4 - all frequency changes happen glitch free
// RULE5 - sync card: clock pin copies bit three
// RULE6 - receive read returns card data bit
// RULE7 - transmit write puts data on io
// RULE8 - software toggles only top select bit
// RULE9 - software changes only halt and level
// RULE10 - delayed source switch flagged when effective
// RULE11 - half rates switch fastest, eighth best duty
// RULE12 - full crystal passes input duty cycle
// RULE13 - select codes: full, half, quarter, eighth, oscillator
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module card_clock_selector
    import card_clock_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_crystal_input,
    input  wire logic        i_int_osc,
    input  wire logic        i_card_io,
    output logic             o_card_clk,
    output logic             o_card_io_out,
    output logic             o_card_io_oe,
    output logic             o_irq
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    card_clock_config_t card_clock_config;
    card_mode_t         card_mode;
    logic [IRQ_W-1:0]   irq_status;
    logic [IRQ_W-1:0]   irq_mask;
    logic [IRQ_W-1:0]   irq_events;
    logic [2:0]         pin_level;
    logic [2:0]         pin_rise;
    logic [2:0]         pin_fall;
    logic               gen_clk;
    logic               osc_active;
    logic               switched;
    logic               halted;
    logic               halted_q;
    logic               req;
    logic               accept;
    logic               wr_lane0;
    logic [7:0]         next_readbyte;

    // address decode shared by read and write paths
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] index);
        return addr == {index[5:0], 2'b00};
    endfunction

    // ****************************************************************
    // pin synchronisers: crystal, oscillator, card data line
    // ****************************************************************
    card_pin_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_pin      ({i_card_io, i_int_osc, i_crystal_input}),
        .o_level    (pin_level),
        .o_rise     (pin_rise),
        .o_fall     (pin_fall)
    );

    // ****************************************************************
    // asynchronous card clock generator
    // ****************************************************************
    card_clk_gen u_clk_gen (
        .i_core_clk   (i_core_clk),
        .i_rst        (i_rst),
        .i_xtal_level (pin_level[0]),
        .i_xtal_rise  (pin_rise[0]),
        .i_xtal_fall  (pin_fall[0]),
        .i_osc_rise   (pin_rise[1]),
        .i_select     (card_clock_config.async_clock_select),
        .i_halt       (card_clock_config.clock_halt),
        .i_stop_high  (card_clock_config.stop_level_high),
        .o_clk        (gen_clk),
        .o_osc_active (osc_active),
        .o_switched   (switched),
        .o_halted     (halted)
    );

    // ****************************************************************
    // bus handshake
    // ****************************************************************

    // a request is taken on the edge where waitrequest is low
    assign req      = i_avs_read || i_avs_write;
    assign accept   = req && !o_avs_waitrequest;
    assign wr_lane0 = i_avs_write && accept && i_avs_byteenable[0];

    // waitrequest drops for one cycle after a request is seen
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            o_avs_waitrequest <= 1'b1;
        else
            o_avs_waitrequest <= !(req && o_avs_waitrequest);
    end

    // ****************************************************************
    // register writes
    // ****************************************************************

    // clock configuration; bits 7 and 6 are not stored
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            card_clock_config <= CFG_RESET;
        end else if (wr_lane0 && reg_hit(i_avs_address, CFG_INDEX)) begin
            card_clock_config                     <= i_avs_writedata[7:0];
            card_clock_config.unused              <= 2'b00;
        end
    end

    // card mode: synchronous card and transmit direction
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            card_mode <= MODE_RESET;
        end else if (wr_lane0 && reg_hit(i_avs_address, MODE_INDEX)) begin
            card_mode        <= i_avs_writedata[7:0];
            card_mode.unused <= 6'h00;
        end
    end

    // transmit data goes straight to the io line
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            o_card_io_out <= 1'b1;
        else if (wr_lane0 && reg_hit(i_avs_address, DATA_INDEX))
            o_card_io_out <= i_avs_writedata[RX_BIT];  // RULE7
    end

    // io driven only in synchronous transmit mode
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            o_card_io_oe <= 1'b0;
        else
            o_card_io_oe <= card_mode.sync_card_mode && card_mode.sync_tx_enable;  // RULE7
    end

    // ****************************************************************
    // card clock pin
    // ****************************************************************

    // sync card copies the software bit, otherwise the generator
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            o_card_clk <= 1'b0;
        else if (card_mode.sync_card_mode)
            o_card_clk <= card_clock_config.sync_card_clock_bit;  // RULE5
        else
            o_card_clk <= gen_clk;  // RULE1 RULE3
    end

    // ****************************************************************
    // events and interrupt
    // ****************************************************************

    // switch took effect, or clock reached its stop level
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            halted_q <= 1'b0;
        else
            halted_q <= halted;
    end

    always_comb begin
        irq_events                 = '0;
        irq_events[IRQ_SWITCH_BIT] = switched;  // RULE10
        irq_events[IRQ_HALT_BIT]   = halted && !halted_q;
    end

    // sticky status, write one to clear, a new event wins over the clear
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            irq_status <= '0;
        else if (wr_lane0 && reg_hit(i_avs_address, IRQ_STATUS_INDEX))
            irq_status <= (irq_status & ~i_avs_writedata[IRQ_W-1:0]) | irq_events;
        else
            irq_status <= irq_status | irq_events;
    end

    // interrupt enables
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            irq_mask <= IRQ_MASK_RESET[IRQ_W-1:0];
        else if (wr_lane0 && reg_hit(i_avs_address, IRQ_MASK_INDEX))
            irq_mask <= i_avs_writedata[IRQ_W-1:0];
    end

    // level interrupt while any enabled event is pending
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            o_irq <= 1'b0;
        else
            o_irq <= |(irq_status & irq_mask);
    end

    // ****************************************************************
    // register reads
    // ****************************************************************

    // read byte selection
    always_comb begin
        next_readbyte = 8'h00;
        if (reg_hit(i_avs_address, CFG_INDEX)) begin
            next_readbyte = card_clock_config;
        end else if (reg_hit(i_avs_address, STATUS_INDEX)) begin
            next_readbyte[SWITCHED_FLAG_BIT] = osc_active;  // RULE10
        end else if (reg_hit(i_avs_address, DATA_INDEX)) begin
            next_readbyte[RX_BIT] = pin_level[2];  // RULE6
        end else if (reg_hit(i_avs_address, MODE_INDEX)) begin
            next_readbyte = card_mode;
        end else if (reg_hit(i_avs_address, IRQ_STATUS_INDEX)) begin
            next_readbyte[IRQ_W-1:0] = irq_status;
        end else if (reg_hit(i_avs_address, IRQ_MASK_INDEX)) begin
            next_readbyte[IRQ_W-1:0] = irq_mask;
        end
    end

    // read data loaded while waitrequest is high, valid at the accept edge
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            o_avs_readdata <= UNMAPPED_READ;
        else if (i_avs_read && o_avs_waitrequest)
            o_avs_readdata <= {24'h00_0000, next_readbyte};
    end

endmodule
`default_nettype wire

// [hw/card_pin_sync.sv]
// two-stage synchroniser with edge detection for asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module card_pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_rise,
    output logic      [WIDTH-1:0] o_fall
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] last;

    // first stage feeds only the second stage
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            meta   <= '0;
            stable <= '0;
            last   <= '0;
        end else begin
            meta   <= i_pin;
            stable <= meta;
            last   <= stable;
        end
    end

    // edges seen between second and third stage
    assign o_level = stable;
    assign o_rise  = stable & ~last;
    assign o_fall  = ~stable & last;
endmodule
`default_nettype wire

// [tb/card_clock_selector_props.sv]
// concurrent checks on the card clock selector ports
`timescale 1ns/10ps
`default_nettype none
module card_clock_selector_props (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_crystal_input,
    input wire logic        i_int_osc,
    input wire logic        i_card_io,
    input wire logic        o_card_clk,
    input wire logic        o_card_io_out,
    input wire logic        o_card_io_oe,
    input wire logic        o_irq
);
    logic [7:0] cfg_q;
    logic [7:0] mode_q;
    logic [1:0] mask_q;
    logic       tx_q;
    logic       acc_w;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // ****************************************************************
    // shadow copies of the registers, updated on accepted writes
    // ****************************************************************
    assign acc_w = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cfg_q <= 8'h00;
            mode_q <= 8'h00;
            mask_q <= 2'h0;
            tx_q <= 1'b1;
        end else if (acc_w) begin
            case (i_avs_address)
                8'h04: cfg_q <= i_avs_writedata[7:0];
                8'h40: mode_q <= i_avs_writedata[7:0];
                8'h48: mask_q <= i_avs_writedata[1:0];
                8'h34: tx_q <= i_avs_writedata[0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_wait_one;
        !o_avs_waitrequest |=> o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    property p_wait_answer;
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("bus answer late");
    property p_read_upper;
        i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("read data upper bits set");
    property p_halt_reach;
        $rose(cfg_q[4]) && !mode_q[0] |-> ##[0:200] o_card_clk == cfg_q[5];
    endproperty
    a_halt_reach: assert property (p_halt_reach) else $error("clock never stopped");
    property p_halt_hold;
        cfg_q[4] && $stable(cfg_q) && !mode_q[0] && o_card_clk == cfg_q[5] && !acc_w
            |=> o_card_clk == cfg_q[5];
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("stopped clock moved");
    property p_sync_copy;
        mode_q[0] && $stable(mode_q) && $stable(cfg_q) |-> o_card_clk == cfg_q[3];
    endproperty
    a_sync_copy: assert property (p_sync_copy) else $error("sync clock not copied");
    property p_tx_drive;
        acc_w && i_avs_address == 8'h34 |-> ##2 o_card_io_out == tx_q;
    endproperty
    a_tx_drive: assert property (p_tx_drive) else $error("io value not driven");
    property p_irq_masked;
        mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !o_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt seen");
    property p_high_min;
        $rose(o_card_clk) && !mode_q[0] |-> o_card_clk [*4];
    endproperty
    a_high_min: assert property (p_high_min) else $error("short high pulse");
    property p_low_min;
        $fell(o_card_clk) && !mode_q[0] |-> !o_card_clk [*4];
    endproperty
    a_low_min: assert property (p_low_min) else $error("short low pulse");
endmodule
bind card_clock_selector card_clock_selector_props u_props (.*);
`default_nettype wire

// [tb/card_clock_selector_test.sv]
// self-checking bench of the card clock selector
`timescale 1ns/10ps
`default_nettype none
module card_clock_selector_test
    import card_clock_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hF;
    logic        xtal = 1'b0;
    logic        osc = 1'b0;
    logic        card_low = 1'b0;
    logic [31:0] rdata;
    logic [31:0] q;
    logic        wreq;
    logic        card_clk;
    logic        io_out;
    logic        io_oe;
    logic        io_wire;
    logic        irq;
    int          num_errors = 0;
    int          checks = 0;
    int          cyc = 0;
    int          per;

    // core clock, crystal at 125 ns, internal oscillator at 160 ns
    always #5 clk = ~clk;
    always #62.5 xtal = ~xtal;
    always #80 osc = ~osc;

    card_clock_selector dut (.i_core_clk(clk), .i_rst(rst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_crystal_input(xtal), .i_int_osc(osc), .i_card_io(io_wire),
        .o_card_clk(card_clk), .o_card_io_out(io_out), .o_card_io_oe(io_oe), .o_irq(irq));
    card_contact_model card (.i_io_out(io_out), .i_io_oe(io_oe), .i_card_low(card_low),
        .o_io_wire(io_wire));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task summarize;
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
        checks++;
        if ((^got === 1'bx) || got + tol < exp || got > exp + tol) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] e);
        addr <= a;
        wdata <= d;
        be <= e;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    // core cycles spanned by eight card clock periods
    task measure(output int p);
        int t0;
        repeat (2) @(posedge card_clk);
        t0 = cyc;
        repeat (8) @(posedge card_clk);
        p = cyc - t0;
    endtask

    // poll the switched flag until it shows the expected source
    task poll(input logic [31:0] exp);
        do
            bus(1'b0, 8'h30, 32'h0, 4'hF);
        while (q[7] !== exp[0]);
        chk(32'(q[7]), exp, 0);
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, 8'h04, 32'h0, 4'hF);
        chk(q, 32'(CFG_RESET), 0);
        bus(1'b0, 8'h48, 32'h0, 4'hF);
        chk(q, 32'(IRQ_MASK_RESET), 0);
        bus(1'b1, 8'h3C, 32'hFF, 4'hF);
        bus(1'b0, 8'h3C, 32'h0, 4'hF);
        chk(q, UNMAPPED_READ, 0);
        bus(1'b1, 8'h04, 32'h3, 4'h0);
        bus(1'b0, 8'h04, 32'h0, 4'hF);
        chk(q, 32'h0, 0);
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, 8'h04, 32'(s), 4'hF);
            measure(per);
            chk(32'(per), 32'(100 << s), 4);
        end
        $display("test crystal rates done");
        bus(1'b1, 8'h04, 32'h7, 4'hF);
        poll(32'h1);
        bus(1'b0, 8'h44, 32'h0, 4'hF);
        chk(q, 32'h1, 0);
        chk(32'(irq), 32'h0, 0);
        bus(1'b1, 8'h48, 32'h3, 4'hF);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h1, 0);
        bus(1'b1, 8'h44, 32'h1, 4'hF);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h0, 0);
        measure(per);
        chk(32'(per), 32'd256, 4);
        $display("test oscillator switch done");
        bus(1'b1, 8'h04, 32'h37, 4'hF);
        repeat (100) @(posedge clk);
        chk(32'(card_clk), 32'h1, 0);
        chk(32'(irq), 32'h1, 0);
        bus(1'b0, 8'h44, 32'h0, 4'hF);
        chk(q, 32'h2, 0);
        bus(1'b1, 8'h44, 32'h2, 4'hF);
        repeat (50) @(posedge clk);
        chk(32'(card_clk), 32'h1, 0);
        bus(1'b1, 8'h04, 32'h17, 4'hF);
        repeat (3) @(posedge clk);
        chk(32'(card_clk), 32'h0, 0);
        bus(1'b1, 8'h04, 32'h07, 4'hF);
        measure(per);
        chk(32'(per), 32'd256, 4);
        $display("test stop done");
        bus(1'b1, 8'h04, 32'h3, 4'hF);
        poll(32'h0);
        measure(per);
        chk(32'(per), 32'd800, 4);
        bus(1'b1, 8'h44, 32'h3, 4'hF);
        bus(1'b1, 8'h04, 32'h13, 4'hF);
        repeat (120) @(posedge clk);
        chk(32'(card_clk), 32'h0, 0);
        $display("test switch back done");
        bus(1'b1, 8'h40, 32'h1, 4'hF);
        bus(1'b1, 8'h04, 32'h08, 4'hF);
        repeat (3) @(posedge clk);
        chk(32'(card_clk), 32'h1, 0);
        bus(1'b1, 8'h04, 32'h00, 4'hF);
        repeat (3) @(posedge clk);
        chk(32'(card_clk), 32'h0, 0);
        for (int b = 0; b < 2; b++) begin
            card_low <= b[0];
            repeat (4) @(posedge clk);
            bus(1'b0, 8'h34, 32'h0, 4'hF);
            chk(32'(q[0]), 32'(!b[0]), 0);
        end
        card_low <= 1'b0;
        bus(1'b1, 8'h40, 32'h3, 4'hF);
        for (int b = 0; b < 2; b++) begin
            bus(1'b1, 8'h34, 32'(b), 4'hF);
            repeat (3) @(posedge clk);
            chk(32'(io_oe), 32'h1, 0);
            chk(32'(io_wire), 32'(b), 0);
        end
        $display("test sync card done");
        summarize();
    end
endmodule
`default_nettype wire

// [tb/card_contact_model.sv]
// card side of the io contact: open-drain line with pull-up
`timescale 1ns/10ps
`default_nettype none
module card_contact_model (
    input  wire logic i_io_out,
    input  wire logic i_io_oe,
    input  wire logic i_card_low,
    output logic      o_io_wire
);
    // either party pulls low, otherwise the pull-up wins
    assign o_io_wire = ((i_io_oe && !i_io_out) || i_card_low) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire
